// file: ocd_pkg.sv
// Shared constants and types of the output clock distribution block
package ocd_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS   = 50000;
    // Least time, so the count rounds up
    localparam int CAL_CYCLES_DEF = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_W          = 16;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int CH_W     = 12;
    localparam int LR_W     = 20;
    localparam int PD_W     = 4;
    localparam int NUM_CH   = 11;
    localparam int NUM_OUT  = 16;
    localparam int NUM_APLL = 3;
    localparam int NUM_SRC  = 6;
    localparam int NUM_ZDM  = 3;

    // ----------------------------------------------------------------
    // Post-divider ranges
    // ----------------------------------------------------------------
    localparam logic [PD_W-1:0] PD_BYPASS   = 4'h1;
    localparam logic [PD_W-1:0] PD_MIN      = 4'h2;
    localparam logic [PD_W-1:0] APLL1_PD_MAX = 4'h7;
    localparam logic [PD_W-1:0] APLL2_PD_MAX = 4'hd;
    localparam logic [PD_W-1:0] APLL3_PD_MAX = 4'h8;
    localparam logic [PD_W-1:0] APLL3_HALF   = 4'h2;

    // ----------------------------------------------------------------
    // Indices: APLLs, post-divider sync bits, channels
    // ----------------------------------------------------------------
    localparam int APLL1 = 0;
    localparam int APLL2 = 1;
    localparam int APLL3 = 2;
    localparam int PSYNC_APLL1_PRI = 0;
    localparam int PSYNC_APLL1_SEC = 1;
    localparam int PSYNC_APLL2     = 2;
    localparam int PSYNC_APLL3     = 3;
    localparam int CH_OUT0   = 0;
    localparam int CH_OUT1   = 1;
    localparam int CH_OUT2   = 2;
    localparam int CH_OUT3   = 3;
    localparam int CH_PAIR4  = 4;
    localparam int CH_PAIR6  = 5;
    localparam int CH_PAIR10 = 7;
    localparam int CH_OUT14  = 9;
    localparam int CH_OUT15  = 10;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_APLL3     = 3'h0,
        SRC_APLL2     = 3'h1,
        SRC_APLL1_PRI = 3'h2,
        SRC_APLL1_SEC = 3'h3,
        SRC_XO        = 3'h4,
        SRC_REF       = 3'h5
    } ocd_src_t;

    typedef enum logic [1:0] {
        CAL_IDLE    = 2'h0,
        CAL_WAIT_XO = 2'h1,
        CAL_RUN     = 2'h3,
        CAL_DONE    = 2'h2
    } ocd_cal_t;

endpackage : ocd_pkg

// file: ocd_divider.sv
// Glitch-free programmable divider on a source tick stream
`timescale 1ns/1ps
`default_nettype none
module ocd_divider #(
    parameter int W = 12
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         tickIn,
    input  wire logic [W-1:0] divValue,
    input  wire logic [W-1:0] delay,
    input  wire logic         hold,
    input  wire logic         load,
    output logic              level,
    output logic              tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] cur;
        logic         level;
        logic         tick;
    } ocd_div_state_t;

    ocd_div_state_t q;
    ocd_div_state_t d;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Zero is taken as bypass so the counter always has a legal period
    function automatic logic [W-1:0] normDiv(input logic [W-1:0] v);
        return (v == '0) ? W'(1) : v;
    endfunction : normDiv

    // An offset beyond the period would stall the count, so it folds to zero
    function automatic logic [W-1:0] startCnt(input logic [W-1:0] dl,
                                              input logic [W-1:0] dv);
        return (dl < dv) ? dl : '0;
    endfunction : startCnt

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (hold) begin
            d.cur   = normDiv(divValue);
            d.cnt   = startCnt(delay, normDiv(divValue));
            d.level = 1'b0;
        end else if (load) begin
            d.cnt = startCnt(delay, q.cur);
        end else if (tickIn) begin
            // A cleared ratio after reset wraps on the first tick instead of a full count
            if (q.cnt >= normDiv(q.cur) - W'(1)) begin
                d.cnt  = '0;
                // New ratio only at a period boundary: no runt pulse
                d.cur  = normDiv(divValue);
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + W'(1);
            end
            if (d.cur == W'(1)) begin
                d.level = ~q.level;
            end else begin
                d.level = d.cnt < (d.cur >> 1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
    assign tick  = q.tick;

endmodule : ocd_divider
`default_nettype wire

// file: ocd_top.sv
// Output clock distribution: post-dividers, bank muxes, channel dividers, calibration
//
// Summary of operation
// - APLL2 post-divider 2..13 feeds every bank
// - APLL1 primary to 0-3,14,15; secondary 0,1
// - APLL3 post-divider 2..8, optional extra half
// - Outputs 0,1 each have six-input selectors
// - Banks 2/3 and 14/15 share three-input selectors
// - Banks 4-7 and 8-13 pick APLL3 or APLL2
// - Outputs 0,1: own channel and low-rate dividers
// - Outputs 2,3,14,15 have own 12-bit dividers
// - Pairs 4/5..12/13 share divider, optional low-rate
// - Total ratio is post times channel times low-rate
// - Divider powers down when its drivers disabled
// - Low-rate divider on all but outputs 2,3
// - Calibration starts after reset once crystal present
// - Outputs muted per output until calibration done
// - Enable rising edge recalibrates that APLL only
// - Static delay offset on channel and low-rate paths
// - Sync alignment; zero-delay mode on 0,4,10
// - Channel divider values 1..4095, 1 bypasses
// - Sync holds enabled non-bypassed dividers low, aligned release
// - Auto-mute while selected source not locked
`timescale 1ns/1ps
`default_nettype none
module ocd_top
    import ocd_pkg::*;
#(
    parameter int CAL_CYCLES = ocd_pkg::CAL_CYCLES_DEF
) (
    input  wire logic                                         clk,
    input  wire logic                                         rstn,
    input  wire logic                                         vco1Tick,
    input  wire logic                                         vco2Tick,
    input  wire logic                                         vco3Tick,
    input  wire logic                                         xoTick,
    input  wire logic                                         refTick,
    input  wire logic                                         xoPresent,
    input  wire logic [ocd_pkg::NUM_APLL-1:0]                 analogLoopEnableBit,
    input  wire logic [ocd_pkg::NUM_APLL-1:0]                 apllLock,
    input  wire logic [ocd_pkg::PD_W-1:0]                     apll1PrimaryPostDivider,
    input  wire logic [ocd_pkg::PD_W-1:0]                     apll1SecondaryPostDivider,
    input  wire logic [ocd_pkg::PD_W-1:0]                     apll2PostDivider,
    input  wire logic [ocd_pkg::PD_W-1:0]                     apll3PostDivider,
    input  wire logic                                         apll3HalfEnable,
    input  wire logic [3:0]                                   postSyncEnable,
    input  wire logic [2:0]                                   muxSelOut0,
    input  wire logic [2:0]                                   muxSelOut1,
    input  wire logic [1:0]                                   muxSelOut2to3,
    input  wire logic [1:0]                                   muxSelOut14to15,
    input  wire logic                                         muxSelOut4to7,
    input  wire logic                                         muxSelOut8to13,
    input  wire logic [ocd_pkg::NUM_CH-1:0][ocd_pkg::CH_W-1:0] channelDivider,
    input  wire logic [ocd_pkg::NUM_CH-1:0][ocd_pkg::CH_W-1:0] channelDelay,
    input  wire logic [ocd_pkg::NUM_CH-1:0]                   lowRateEnable,
    input  wire logic [ocd_pkg::NUM_CH-1:0][ocd_pkg::LR_W-1:0] lowRateDivider,
    input  wire logic [ocd_pkg::NUM_CH-1:0][ocd_pkg::LR_W-1:0] lowRateDelay,
    input  wire logic [ocd_pkg::NUM_CH-1:0]                   dividerPowerDown,
    input  wire logic [ocd_pkg::NUM_OUT-1:0]                  driverEnable,
    input  wire logic [ocd_pkg::NUM_OUT-1:0]                  muteEnable,
    input  wire logic                                         syncIn,
    input  wire logic                                         syncEnable,
    input  wire logic [ocd_pkg::NUM_CH-1:0]                   channelSyncEnable,
    input  wire logic [ocd_pkg::NUM_CH-1:0]                   lowRateSyncEnable,
    input  wire logic [ocd_pkg::NUM_ZDM-1:0]                  zeroDelayAlignmentMode,
    output logic      [ocd_pkg::NUM_OUT-1:0]                  outClk,
    output logic      [ocd_pkg::NUM_OUT-1:0]                  outMuted,
    output logic      [ocd_pkg::NUM_APLL-1:0]                 calDone
);
    import ocd_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_APLL-1:0]            enPrev;
        ocd_cal_t [NUM_APLL-1:0]        cal;
        logic [NUM_APLL-1:0][CAL_W-1:0] calCnt;
        logic [NUM_OUT-1:0]             outClk;
        logic [NUM_OUT-1:0]             muted;
    } ocd_top_state_t;

    ocd_top_state_t q;
    ocd_top_state_t d;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [PD_W-1:0] clampDiv(input logic [PD_W-1:0] v,
                                                 input logic [PD_W-1:0] hi);
        if (v < PD_MIN) begin
            return PD_MIN;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clampDiv

    // Channel that drives each output pin
    function automatic int chanOf(input int o);
        if (o < 4) begin
            return o;
        end else if (o < 14) begin
            return 4 + (o - 4) / 2;
        end
        return o - 5;
    endfunction : chanOf

    // Unused selector codes fall back to the APLL3 path
    function automatic ocd_src_t muxSource(input int c);
        logic [2:0] raw;
        raw = 3'h0;
        case (c)
            CH_OUT0: begin
                raw = (muxSelOut0 > 3'h5) ? 3'h0 : muxSelOut0;
            end
            CH_OUT1: begin
                raw = (muxSelOut1 > 3'h5) ? 3'h0 : muxSelOut1;
            end
            CH_OUT2, CH_OUT3: begin
                raw = (muxSelOut2to3 > 2'h2) ? 3'h0 : {1'b0, muxSelOut2to3};
            end
            CH_OUT14, CH_OUT15: begin
                raw = (muxSelOut14to15 > 2'h2) ? 3'h0 : {1'b0, muxSelOut14to15};
            end
            CH_PAIR4, CH_PAIR6: begin
                raw = {2'h0, muxSelOut4to7};
            end
            default: begin
                raw = {2'h0, muxSelOut8to13};
            end
        endcase
        return ocd_src_t'(raw);
    endfunction : muxSource

    function automatic logic srcValid(input ocd_src_t s);
        logic ok;
        ok = 1'b1;
        case (s)
            SRC_APLL3:     ok = calDone[APLL3] & apllLock[APLL3];
            SRC_APLL2:     ok = calDone[APLL2] & apllLock[APLL2];
            SRC_APLL1_PRI,
            SRC_APLL1_SEC: ok = calDone[APLL1] & apllLock[APLL1];
            default:       ok = 1'b1;
        endcase
        return ok;
    endfunction : srcValid

    // ----------------------------------------------------------------
    // VCO post-dividers
    // ----------------------------------------------------------------
    logic               syncActive;
    logic [PD_W-1:0]    apll3Main;
    logic [PD_W-1:0]    apll3Half;
    logic               apll3MainTick;
    logic [NUM_SRC-1:0] srcTick;

    assign syncActive = syncIn & syncEnable;
    // Setting 1 bypasses the APLL3 post-divider and its half stage
    assign apll3Main  = (apll3PostDivider <= PD_BYPASS) ? PD_BYPASS
                      : clampDiv(apll3PostDivider, APLL3_PD_MAX);
    assign apll3Half  = (apll3HalfEnable && apll3Main != PD_BYPASS)
                      ? APLL3_HALF : PD_BYPASS;
    assign srcTick[SRC_XO]  = xoTick;
    assign srcTick[SRC_REF] = refTick;

    ocd_divider #(.W(PD_W)) uApll1Pri (
        .clk      (clk),
        .rstn     (rstn),
        .tickIn   (vco1Tick),
        .divValue (clampDiv(apll1PrimaryPostDivider, APLL1_PD_MAX)),
        .delay    ('0),
        .hold     (syncActive & postSyncEnable[PSYNC_APLL1_PRI]),
        .load     (1'b0),
        .level    (),
        .tick     (srcTick[SRC_APLL1_PRI])
    );

    ocd_divider #(.W(PD_W)) uApll1Sec (
        .clk      (clk),
        .rstn     (rstn),
        .tickIn   (vco1Tick),
        .divValue (clampDiv(apll1SecondaryPostDivider, APLL1_PD_MAX)),
        .delay    ('0),
        .hold     (syncActive & postSyncEnable[PSYNC_APLL1_SEC]),
        .load     (1'b0),
        .level    (),
        .tick     (srcTick[SRC_APLL1_SEC])
    );

    ocd_divider #(.W(PD_W)) uApll2 (
        .clk      (clk),
        .rstn     (rstn),
        .tickIn   (vco2Tick),
        .divValue (clampDiv(apll2PostDivider, APLL2_PD_MAX)),
        .delay    ('0),
        .hold     (syncActive & postSyncEnable[PSYNC_APLL2]),
        .load     (1'b0),
        .level    (),
        .tick     (srcTick[SRC_APLL2])
    );

    ocd_divider #(.W(PD_W)) uApll3Main (
        .clk      (clk),
        .rstn     (rstn),
        .tickIn   (vco3Tick),
        .divValue (apll3Main),
        .delay    ('0),
        .hold     (syncActive & postSyncEnable[PSYNC_APLL3]),
        .load     (1'b0),
        .level    (),
        .tick     (apll3MainTick)
    );

    ocd_divider #(.W(PD_W)) uApll3Half (
        .clk      (clk),
        .rstn     (rstn),
        .tickIn   (apll3MainTick),
        .divValue (apll3Half),
        .delay    ('0),
        .hold     (syncActive & postSyncEnable[PSYNC_APLL3]),
        .load     (1'b0),
        .level    (),
        .tick     (srcTick[SRC_APLL3])
    );

    // ----------------------------------------------------------------
    // Channel routing, power-down and sync
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] chanTickIn;
    logic [NUM_CH-1:0] chanHold;
    logic [NUM_CH-1:0] lowHold;
    logic [NUM_CH-1:0] zdmLoad;
    logic [NUM_CH-1:0] chanUsed;

    always_comb begin
        chanUsed = '0;
        for (int o = 0; o < NUM_OUT; o++) begin
            if (driverEnable[o]) begin
                chanUsed[chanOf(o)] = 1'b1;
            end
        end
        zdmLoad = '0;
        zdmLoad[CH_OUT0]   = zeroDelayAlignmentMode[0] & refTick;
        zdmLoad[CH_PAIR4]  = zeroDelayAlignmentMode[1] & refTick;
        zdmLoad[CH_PAIR10] = zeroDelayAlignmentMode[2] & refTick;
        for (int c = 0; c < NUM_CH; c++) begin
            chanTickIn[c] = srcTick[muxSource(c)];
            // Bypassed dividers keep running through a sync event
            chanHold[c] = dividerPowerDown[c] | ~chanUsed[c]
                        | (syncActive & channelSyncEnable[c]
                           & (channelDivider[c] > CH_W'(1)));
            lowHold[c]  = chanHold[c] | ~lowRateEnable[c]
                        | (syncActive & channelSyncEnable[c]
                           & lowRateSyncEnable[c]);
        end
    end

    // ----------------------------------------------------------------
    // Channel and low-rate dividers
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] chanLevel;
    logic [NUM_CH-1:0] chanTick;
    logic [NUM_CH-1:0] lowLevel;
    logic [NUM_CH-1:0] finalLevel;

    for (genvar c = 0; c < NUM_CH; c++) begin : gChan
        ocd_divider #(.W(CH_W)) uChan (
            .clk      (clk),
            .rstn     (rstn),
            .tickIn   (chanTickIn[c]),
            .divValue (channelDivider[c]),
            .delay    (channelDelay[c]),
            .hold     (chanHold[c]),
            .load     (zdmLoad[c]),
            .level    (chanLevel[c]),
            .tick     (chanTick[c])
        );
        if (c != CH_OUT2 && c != CH_OUT3) begin : gLow
            ocd_divider #(.W(LR_W)) uLow (
                .clk      (clk),
                .rstn     (rstn),
                .tickIn   (chanTick[c]),
                .divValue (lowRateDivider[c]),
                .delay    (lowRateDelay[c]),
                .hold     (lowHold[c]),
                .load     (zdmLoad[c]),
                .level    (lowLevel[c]),
                .tick     ()
            );
            assign finalLevel[c] = lowRateEnable[c] ? lowLevel[c] : chanLevel[c];
        end else begin : gNoLow
            assign lowLevel[c]   = 1'b0;
            assign finalLevel[c] = chanLevel[c];
        end
    end

    // ----------------------------------------------------------------
    // Calibration sequencing and output muting
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.enPrev = analogLoopEnableBit;
        for (int k = 0; k < NUM_APLL; k++) begin
            case (q.cal[k])
                CAL_IDLE: begin
                    // Reset clears the edge history, so reset acts as a trigger
                    if (analogLoopEnableBit[k] && !q.enPrev[k]) begin
                        d.cal[k] = CAL_WAIT_XO;
                    end
                end
                CAL_WAIT_XO: begin
                    if (!analogLoopEnableBit[k]) begin
                        d.cal[k] = CAL_IDLE;
                    end else if (xoPresent) begin
                        d.cal[k]    = CAL_RUN;
                        d.calCnt[k] = CAL_W'(CAL_CYCLES - 1);
                    end
                end
                CAL_RUN: begin
                    if (!analogLoopEnableBit[k]) begin
                        d.cal[k] = CAL_IDLE;
                    end else if (q.calCnt[k] == '0) begin
                        d.cal[k] = CAL_DONE;
                    end else begin
                        d.calCnt[k] = q.calCnt[k] - CAL_W'(1);
                    end
                end
                CAL_DONE: begin
                    if (!analogLoopEnableBit[k]) begin
                        d.cal[k] = CAL_IDLE;
                    end
                end
                default: begin
                    d.cal[k] = CAL_IDLE;
                end
            endcase
        end
        for (int o = 0; o < NUM_OUT; o++) begin
            d.muted[o]  = muteEnable[o] & ~srcValid(muxSource(chanOf(o)));
            d.outClk[o] = driverEnable[o] & ~d.muted[o] & finalLevel[chanOf(o)];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q.enPrev <= '0;
            q.cal    <= '{default: CAL_IDLE};
            q.calCnt <= '0;
            q.outClk <= '0;
            q.muted  <= '1;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        for (int k = 0; k < NUM_APLL; k++) begin
            calDone[k] = (q.cal[k] == CAL_DONE);
        end
    end

    assign outClk   = q.outClk;
    assign outMuted = q.muted;

endmodule : ocd_top
`default_nettype wire

// file: ocd_top_properties.sv
// Property checker for the output clock distribution block
`timescale 1ns/1ps
`default_nettype none
module ocd_top_properties #(
    parameter int CAL_CYCLES = 4
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              xoPresent,
    input wire logic [2:0]        analogLoopEnableBit,
    input wire logic [2:0]        apllLock,
    input wire logic              muxSelOut4to7,
    input wire logic [10:0][11:0] channelDivider,
    input wire logic [10:0]       dividerPowerDown,
    input wire logic [15:0]       muteEnable,
    input wire logic              syncIn,
    input wire logic              syncEnable,
    input wire logic [10:0]       channelSyncEnable,
    input wire logic [15:0]       outClk,
    input wire logic [15:0]       outMuted,
    input wire logic [2:0]        calDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_cal_after_xo: assert property ($rose(calDone[0]) |-> $past(xoPresent, CAL_CYCLES))
        else $error("cal done early");
    a_cal_drop_off: assert property (!analogLoopEnableBit[1] |=> !calDone[1])
        else $error("cal done kept");
    a_recal_fresh: assert property ($rose(analogLoopEnableBit[1]) |=> !calDone[1] [*3])
        else $error("recal skipped");
    a_mute_uncal: assert property ((muteEnable[4] && !muxSelOut4to7 && !calDone[2]) [*2]
        |-> outMuted[4]) else $error("out4 unmuted");
    a_mute_select: assert property (!muteEnable[15] [*2] |-> !outMuted[15])
        else $error("out15 muted");
    a_lock_mute: assert property ((muteEnable[6] && muxSelOut4to7 && !apllLock[1]) [*2]
        |-> outMuted[6]) else $error("out6 unmuted");
    a_sync_hold: assert property ((syncIn && syncEnable && channelSyncEnable[2]
        && channelDivider[2] > 12'h1) [*3] |-> !outClk[2]) else $error("out2 runs in sync");
    a_pd_low: assert property (dividerPowerDown[2] [*3] |-> !outClk[2])
        else $error("out2 runs powered down");
endmodule : ocd_top_properties
bind ocd_top ocd_top_properties #(.CAL_CYCLES(CAL_CYCLES)) i_ocd_top_properties (.clk, .rstn,
    .xoPresent, .analogLoopEnableBit, .apllLock, .muxSelOut4to7, .channelDivider,
    .dividerPowerDown, .muteEnable, .syncIn, .syncEnable, .channelSyncEnable, .outClk,
    .outMuted, .calDone);
`default_nettype wire

// file: ocd_apll_model.sv
// Behavioural model of the three analog loops: VCO ticks and lock
`timescale 1ns/1ps
`default_nettype none
module ocd_apll_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] enable,
    input  wire logic [2:0] calDone,
    output logic      [2:0] tick,
    output logic      [2:0] lock
);
    // Lock trails calibration by a cycle and drops a cycle after the enable falls
    always_ff @(posedge clk) begin
        lock <= rstn ? calDone & enable : 3'h0;
    end
    assign tick = enable;
endmodule : ocd_apll_model
`default_nettype wire

// file: ocd_top_test.sv
// Self-checking bench for the output clock distribution block
`timescale 1ns/1ps
`default_nettype none
module ocd_top_test;
    localparam int CAL = 4;
    logic clk = 1'b0, rstn = 1'b0, xoTick = 1'b0, refTick = 1'b0, xoPresent = 1'b0;
    logic syncIn = 1'b0, syncEnable = 1'b1, apll3HalfEnable = 1'b1, muxSelOut4to7 = 1'b1;
    logic muxSelOut8to13 = 1'b0;
    logic [2:0] analogLoopEnableBit = 3'h7, zeroDelayAlignmentMode = 3'h0;
    logic [2:0] muxSelOut0 = 3'h4, muxSelOut1 = 3'h1;
    logic [1:0] muxSelOut2to3 = 2'h2, muxSelOut14to15 = 2'h1;
    logic [3:0] apll1PrimaryPostDivider = 4'h3, apll1SecondaryPostDivider = 4'h7;
    logic [3:0] apll2PostDivider = 4'hd, apll3PostDivider = 4'h5, postSyncEnable = 4'hf;
    logic [10:0][11:0] channelDelay = '0;
    logic [10:0][11:0] channelDivider = {{4{12'h4}}, 12'h2, 12'h4, 12'h1, {4{12'h4}}};
    logic [10:0] lowRateEnable = 11'h40, lowRateSyncEnable = '0, dividerPowerDown = '0;
    logic [10:0] channelSyncEnable = 11'hc;
    logic [10:0][19:0] lowRateDivider = {11{20'h2}}, lowRateDelay = '0;
    logic [15:0] driverEnable = 16'hffff, muteEnable = 16'h7fff;
    wire vco1Tick, vco2Tick, vco3Tick;
    wire [2:0] apllLock, calDone;
    wire [15:0] outClk, outMuted;
    int errorCnt = 0, numChecks = 0;

    ocd_top #(.CAL_CYCLES(CAL)) i_ocd_top (.clk, .rstn, .vco1Tick, .vco2Tick, .vco3Tick,
        .xoTick, .refTick, .xoPresent, .analogLoopEnableBit, .apllLock,
        .apll1PrimaryPostDivider, .apll1SecondaryPostDivider, .apll2PostDivider,
        .apll3PostDivider, .apll3HalfEnable, .postSyncEnable, .muxSelOut0, .muxSelOut1,
        .muxSelOut2to3, .muxSelOut14to15, .muxSelOut4to7, .muxSelOut8to13, .channelDivider,
        .channelDelay, .lowRateEnable, .lowRateDivider, .lowRateDelay, .dividerPowerDown,
        .driverEnable, .muteEnable, .syncIn, .syncEnable, .channelSyncEnable,
        .lowRateSyncEnable, .zeroDelayAlignmentMode, .outClk, .outMuted, .calDone);
    ocd_apll_model i_ocd_apll_model (.clk, .rstn, .enable(analogLoopEnableBit), .calDone,
        .tick({vco3Tick, vco2Tick, vco1Tick}), .lock(apllLock));

    always #5 clk = ~clk;
    // Crystal ticks every other cycle; reference on two consecutive cycles of every four
    always @(posedge clk) {refTick, xoTick} <= {refTick, xoTick} + 2'h1;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Skips to the next rising edge, then counts one high and one low phase
    task automatic meas(input int o, input int h, input int l);
        int c[4];
        c = '{0, 0, 0, 0};
        for (int k = 0; k < 4; k++) begin
            while ((outClk[o] === 1'b1) == (k % 2 == 0) && c[k] < 9000) begin
                @(posedge clk);
                #1;
                c[k]++;
            end
        end
        chk(c[2], h);
        chk(c[3], l);
    endtask : meas

    task automatic finalReport();
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finalReport

    initial begin
        #300000;
        errorCnt++;
        finalReport();
    end

    initial begin
        repeat (2) @(posedge clk);
        #1 chk({outClk, outMuted, 13'h0, calDone}, 48'h0000ffff0000);
        @(posedge clk) rstn <= 1'b1;
        repeat (20) @(posedge clk);
        #1 chk(calDone, 3'h0);
        @(posedge clk) xoPresent <= 1'b1;
        repeat (CAL) @(posedge clk);
        #1 chk(calDone, 3'h0);
        repeat (2) @(posedge clk);
        #1 chk(calDone, 3'h7);
        repeat (4) @(posedge clk);
        #1 chk(outMuted, 16'h0);
        @(posedge clk) analogLoopEnableBit <= 3'h5;
        @(posedge clk) analogLoopEnableBit <= 3'h7;
        repeat (3) @(posedge clk);
        #1 chk({calDone, outMuted}, {3'h5, 16'h40f2});
        repeat (CAL + 4) @(posedge clk);
        #1 chk(calDone, 3'h7);
        meas(0, 4, 4);
        meas(2, 6, 6);
        meas(4, 13, 13);
        meas(8, 20, 20);
        meas(12, 20, 20);
        meas(14, 26, 26);
        // Idle output 3 across one source tick so only sync can bring it back in phase
        @(posedge outClk[2]);
        driverEnable <= 16'hfff7;
        repeat (3) @(posedge clk);
        driverEnable <= 16'hffff;
        @(posedge clk) syncIn <= 1'b1;
        repeat (10) @(posedge clk);
        #1 chk(outClk[3:2], 2'h0);
        @(posedge clk) syncIn <= 1'b0;
        repeat (30) begin
            @(posedge clk);
            #1 chk(outClk[2], outClk[3]);
        end
        @(posedge clk);
        dividerPowerDown <= 11'h4;
        driverEnable <= 16'hffcf;
        repeat (5) @(posedge clk);
        repeat (30) begin
            @(posedge clk);
            #1 chk({outClk[5:4], outClk[2]}, 3'h0);
        end
        @(posedge clk) {muxSelOut4to7, analogLoopEnableBit} <= 4'h3;
        repeat (3) @(posedge clk);
        #1 chk(outMuted[7:4], 4'hf);
        finalReport();
    end
endmodule : ocd_top_test
`default_nettype wire
